// file: common/lmsr_pkg.sv
package lmsr_pkg;

   // ==========================================================
   // System clock
   localparam int SYS_CLK_HZ              = 20_000_000;
   localparam int SYS_CLK_PERIOD_NS       = 50;

   // ==========================================================
   // Panel geometry
   localparam int COLUMNS                 = 5;
   localparam int ROWS                    = 7;
   localparam int CHARS_PER_PACKAGE       = 4;
   localparam int STAGES_PER_PACKAGE      = 28;
   localparam int SYMBOL_W                = 7;
   localparam int ROW_W                   = 3;
   localparam logic [2:0] ROW_FIRST       = 3'h7;
   localparam logic [2:0] ROW_LAST        = 3'h1;
   localparam logic [2:0] COL_LAST        = 3'h4;

   // ==========================================================
   // Shift clock timing
   localparam int SHIFT_CLK_MAX_HZ        = 3_000_000;
   localparam int SHIFT_CLK_MIN_PERIOD_NS = 1_000_000_000 / SHIFT_CLK_MAX_HZ;
   localparam int SHIFT_CLK_MIN_WIDTH_NS  = 75;
   // Least time: round up, each half at least half the period
   localparam int HALF_FROM_PERIOD        =
      (SHIFT_CLK_MIN_PERIOD_NS + 2 * SYS_CLK_PERIOD_NS - 1) / (2 * SYS_CLK_PERIOD_NS);
   localparam int HALF_FROM_WIDTH         =
      (SHIFT_CLK_MIN_WIDTH_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int SHIFT_HALF_CYCLES       =
      (HALF_FROM_PERIOD > HALF_FROM_WIDTH) ? HALF_FROM_PERIOD : HALF_FROM_WIDTH;

   // ==========================================================
   // Column slot timing
   localparam int REFRESH_MIN_HZ          = 100;
   localparam int SLOT_TIME_US            = 2000;
   // Longest time: round down
   localparam int SLOT_CYCLES             = SLOT_TIME_US * (SYS_CLK_HZ / 1_000_000);

   // ==========================================================
   // Decoder answer latency in cycles after a request changes
   localparam int DEC_LATENCY             = 1;
   // Worst cycles per shifted bit: read, decode, wait, two clock halves
   localparam int BIT_CYCLES              = 3 + DEC_LATENCY + 2 * SHIFT_HALF_CYCLES;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [SYMBOL_W-1:0] symbol;
      logic [ROW_W-1:0]    row;
   } lmsr_dec_req_t;

   typedef struct packed {
      logic               shift_clock;
      logic               data;
      logic               blank_input;
      logic [COLUMNS-1:0] column;
   } lmsr_panel_t;

   localparam lmsr_panel_t PANEL_RESET    = 8'h80;
   localparam lmsr_dec_req_t DEC_RESET    = 10'h007;

endpackage : lmsr_pkg

// file: design/lmsr_refresh_ctrl.sv
// Behaviour
// - Column current off during whole load.
// - Packages chain output to next input.
// - Per column: load rows, then energise column.
// - Column slot at most two milliseconds.
// - Adjustable blank before each load dims.
// - Load, on and blank fit slot.
// - Fetch symbols last character first.
// - Decoder gives five column bits; pick one.
// - Rows shifted seven first, one last.
// - Slot counter: blank, one load, rest displayed.
`timescale 1ns/1ns
`default_nettype none

module lmsr_refresh_ctrl #(
   parameter int CHARS       = 4,
   parameter int SLOT_CYCLES = lmsr_pkg::SLOT_CYCLES,
   parameter int BLANK_W     = 16,
   parameter int AW          = (CHARS > 1) ? $clog2(CHARS) : 1
) (
   input  wire logic                          CLOCK_I,
   input  wire logic                          SRST_I,
   input  wire logic                          SYM_WR_I,
   input  wire logic [AW-1:0]                 SYM_ADDR_I,
   input  wire logic [lmsr_pkg::SYMBOL_W-1:0] SYM_DATA_I,
   input  wire logic [BLANK_W-1:0]            BLANK_TIME_I,
   input  wire logic [lmsr_pkg::COLUMNS-1:0]  DEC_COLS_I,
   output var  lmsr_pkg::lmsr_dec_req_t       DEC_REQ_O,
   output var  lmsr_pkg::lmsr_panel_t         PANEL_O,
   output var  logic                          SLOT_START_O
);

   // ==========================================================
   // Derived sizes
   localparam int LOAD_CYCLES = CHARS * lmsr_pkg::ROWS * lmsr_pkg::BIT_CYCLES;
   localparam int SLOT_W      = $clog2(SLOT_CYCLES + 1);
   localparam int BLANK_MAX   = SLOT_CYCLES - LOAD_CYCLES - 3;
   localparam int PH_W        = 4;
   localparam logic [SLOT_W-1:0] SLOT_END  = SLOT_W'(SLOT_CYCLES - 1);
   localparam logic [PH_W-1:0]   HALF_END  = PH_W'(lmsr_pkg::SHIFT_HALF_CYCLES - 1);
   localparam logic [PH_W-1:0]   DEC_END   = PH_W'(lmsr_pkg::DEC_LATENCY);
   localparam logic [AW-1:0]     CHAR_LAST = AW'(CHARS - 1);

   // ==========================================================
   // Elaboration checks
   if ((CHARS < lmsr_pkg::CHARS_PER_PACKAGE) ||
       ((CHARS % lmsr_pkg::CHARS_PER_PACKAGE) != 0)) begin : g_bad_chars
      // Whole packages only, 28 stages each
      $error("CHARS must be a nonzero multiple of four");
   end
   if (BLANK_MAX < 0) begin : g_bad_slot
      $error("SLOT_CYCLES too short for the load");
   end
   if ((lmsr_pkg::SHIFT_HALF_CYCLES - 1) >= (1 << PH_W)) begin : g_bad_half
      $error("Shift clock half period exceeds phase counter");
   end

   // ==========================================================
   // Helpers
   function automatic logic [SLOT_W-1:0] clamp_blank(input logic [BLANK_W-1:0] t);
      // Leaves room for load and at least one on cycle
      if (int'(t) > BLANK_MAX) begin
         clamp_blank = SLOT_W'(BLANK_MAX);
      end else begin
         clamp_blank = SLOT_W'(t);
      end
   endfunction : clamp_blank

   function automatic logic [2:0] next_column(input logic [2:0] c);
      if (c == lmsr_pkg::COL_LAST) begin
         next_column = 3'h0;
      end else begin
         next_column = c + 3'h1;
      end
   endfunction : next_column

   // ==========================================================
   // Symbol store
   logic [AW-1:0]                 char_idx;
   logic [lmsr_pkg::SYMBOL_W-1:0] sym_rd;

   lmsr_symbol_ram #(
      .DEPTH     (CHARS),
      .WIDTH     (lmsr_pkg::SYMBOL_W),
      .AW        (AW)
   ) u_ram (
      .clk_i     (CLOCK_I),
      .wr_en_i   (SYM_WR_I),
      .wr_addr_i (SYM_ADDR_I),
      .wr_data_i (SYM_DATA_I),
      .rd_addr_i (char_idx),
      .rd_data_o (sym_rd)
   );

   // ==========================================================
   // Sequencer state
   typedef enum logic [2:0] {
      S_BLANK,
      S_READ,
      S_DECODE,
      S_WAIT,
      S_HIGH,
      S_LOW,
      S_ON
   } lmsr_state_t;

   lmsr_state_t               state;
   lmsr_state_t               next_state;
   logic [SLOT_W-1:0]         slot;
   logic [SLOT_W-1:0]         next_slot;
   logic [SLOT_W-1:0]         blank_len;
   logic [SLOT_W-1:0]         next_blank_len;
   logic [PH_W-1:0]           phase;
   logic [PH_W-1:0]           next_phase;
   logic [AW-1:0]             next_char_idx;
   logic [2:0]                row;
   logic [2:0]                next_row;
   logic [2:0]                col;
   logic [2:0]                next_col;
   lmsr_pkg::lmsr_dec_req_t   next_dec_req;
   lmsr_pkg::lmsr_panel_t     next_panel;
   logic                      next_slot_start;

   always_comb begin
      next_state      = state;
      next_slot       = slot + SLOT_W'(1);
      next_blank_len  = blank_len;
      next_phase      = phase;
      next_char_idx   = char_idx;
      next_row        = row;
      next_col        = col;
      next_dec_req    = DEC_REQ_O;
      next_panel      = PANEL_O;
      next_slot_start = 1'b0;

      // Slot counter: one slot of fixed length per column
      if (slot == SLOT_END) begin
         next_slot       = '0;
         next_state      = S_BLANK;
         next_col        = next_column(col);
         next_blank_len  = clamp_blank(BLANK_TIME_I);
         next_char_idx   = CHAR_LAST;
         next_row        = lmsr_pkg::ROW_FIRST;
         next_phase      = '0;
         next_slot_start = 1'b1;
         next_panel.column      = '0;
         next_panel.blank_input = 1'b0;
         next_panel.shift_clock = 1'b1;
      end else begin
         case (state)
            S_BLANK: begin
               // Dark and quiet while the dimming time runs
               next_panel.column      = '0;
               next_panel.blank_input = 1'b0;
               if (slot >= blank_len) begin
                  next_state = S_READ;
               end
            end
            S_READ: begin
               // Memory samples char_idx this cycle
               next_state = S_DECODE;
            end
            S_DECODE: begin
               next_dec_req.symbol = sym_rd;
               next_dec_req.row    = row;
               next_phase          = '0;
               next_state          = S_WAIT;
            end
            S_WAIT: begin
               if (phase == DEC_END) begin
                  // Pick the bit of the current column
                  next_panel.data = DEC_COLS_I[col];
                  next_phase      = '0;
                  next_state      = S_HIGH;
               end else begin
                  next_phase = phase + PH_W'(1);
               end
            end
            S_HIGH: begin
               // Data settles a full half period before the fall
               if (phase == HALF_END) begin
                  next_panel.shift_clock = 1'b0;
                  next_phase             = '0;
                  next_state             = S_LOW;
               end else begin
                  next_phase = phase + PH_W'(1);
               end
            end
            S_LOW: begin
               if (phase == HALF_END) begin
                  next_panel.shift_clock = 1'b1;
                  next_phase             = '0;
                  if (row == lmsr_pkg::ROW_LAST) begin
                     // Seven bits per character, then the previous one
                     next_row = lmsr_pkg::ROW_FIRST;
                     if (char_idx == '0) begin
                        // Last bit loaded reaches character one
                        next_state = S_ON;
                     end else begin
                        next_char_idx = char_idx - AW'(1);
                        next_state    = S_READ;
                     end
                  end else begin
                     next_row   = row - 3'h1;
                     next_state = S_READ;
                  end
               end else begin
                  next_phase = phase + PH_W'(1);
               end
            end
            S_ON: begin
               // Only now does column current flow
               next_panel.blank_input = 1'b1;
               next_panel.column      = 5'h01 << col;
            end
            default: begin
               next_state = S_BLANK;
            end
         endcase
      end

      // Load never overlaps column current
      if (state != S_ON && next_state != S_ON) begin
         next_panel.column      = '0;
         next_panel.blank_input = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         state        <= S_BLANK;
         slot         <= '0;
         blank_len    <= '0;
         phase        <= '0;
         char_idx     <= CHAR_LAST;
         row          <= lmsr_pkg::ROW_FIRST;
         col          <= 3'h0;
         DEC_REQ_O    <= lmsr_pkg::DEC_RESET;
         PANEL_O      <= lmsr_pkg::PANEL_RESET;
         SLOT_START_O <= 1'b0;
      end else begin
         state        <= next_state;
         slot         <= next_slot;
         blank_len    <= next_blank_len;
         phase        <= next_phase;
         char_idx     <= next_char_idx;
         row          <= next_row;
         col          <= next_col;
         DEC_REQ_O    <= next_dec_req;
         PANEL_O      <= next_panel;
         SLOT_START_O <= next_slot_start;
      end
   end

endmodule : lmsr_refresh_ctrl

`default_nettype wire

// file: design/lmsr_symbol_ram.sv
`timescale 1ns/1ns
`default_nettype none

module lmsr_symbol_ram #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 7,
   parameter int AW    = 2
) (
   input  wire logic             clk_i,
   input  wire logic             wr_en_i,
   input  wire logic [AW-1:0]    wr_addr_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   input  wire logic [AW-1:0]    rd_addr_i,
   output var  logic [WIDTH-1:0] rd_data_o
);

   // ==========================================================
   // Storage, read data registered
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end

endmodule : lmsr_symbol_ram

`default_nettype wire

// file: tb/lmsr_panel_model.sv
`timescale 1ns/1ns
`default_nettype none
module lmsr_panel_model #(
   parameter int CHARS = 4
) (
   input  wire lmsr_pkg::lmsr_panel_t panel_i,
   output var  logic [7*CHARS-1:0]    stage_o,
   output wire logic [7*CHARS-1:0]    lit_o,
   output wire logic                  sout_o
);
   // ====================
   // Row chain
   // Two 14-stage halves per package, seen as one chain; no reset
   always @(negedge panel_i.shift_clock) begin
      stage_o <= {stage_o[7*CHARS-2:0], panel_i.data};
   end
   assign sout_o = stage_o[7*CHARS-1];
   // Lit rows of the driven column, shared by all characters
   assign lit_o = stage_o & {(7*CHARS){panel_i.blank_input && (|panel_i.column)}};
endmodule : lmsr_panel_model
`default_nettype wire

// file: tb/lmsr_refresh_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module lmsr_refresh_ctrl_monitor #(
   parameter int CHARS       = 4,
   parameter int SLOT_CYCLES = lmsr_pkg::SLOT_CYCLES
) (
   input wire logic                    CLOCK_I,
   input wire logic                    SRST_I,
   input wire lmsr_pkg::lmsr_dec_req_t DEC_REQ_O,
   input wire lmsr_pkg::lmsr_panel_t   PANEL_O,
   input wire logic                    SLOT_START_O
);
   // ====================
   // Slot bookkeeping
   int unsigned cnt;
   int unsigned falls;
   logic        seen;
   logic        prev_sc;
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);
   // First slot after reset has no full history, so it is skipped
   always_ff @(posedge CLOCK_I) begin
      prev_sc <= PANEL_O.shift_clock;
      if (SRST_I || SLOT_START_O) begin
         cnt   <= 0;
         falls <= 0;
         seen  <= !SRST_I;
      end else begin
         cnt   <= cnt + 1;
         falls <= falls + ((prev_sc && !PANEL_O.shift_clock) ? 1 : 0);
      end
   end
   // ====================
   // Properties
   AST_SLOT_LEN: assert property (SLOT_START_O && seen |-> cnt == SLOT_CYCLES - 1)
      else $error("slot length wrong");
   AST_FALL_CNT: assert property (SLOT_START_O && seen |-> falls == 7 * CHARS)
      else $error("shift edge count wrong");
   AST_LOAD_DARK: assert property (!PANEL_O.shift_clock |->
      PANEL_O.column == 5'h00 && !PANEL_O.blank_input)
      else $error("column current during load");
   AST_ONE_COL: assert property (|PANEL_O.column |->
      $onehot(PANEL_O.column) && PANEL_O.blank_input)
      else $error("column drive not single");
   AST_SLOT_END: assert property (SLOT_START_O |->
      PANEL_O.column == 5'h00 && !PANEL_O.blank_input)
      else $error("column still on at slot start");
   AST_LOW_HALF: assert property ($fell(PANEL_O.shift_clock) |->
      !PANEL_O.shift_clock [*4] ##1 PANEL_O.shift_clock)
      else $error("shift clock low phase wrong");
   AST_DATA_HOLD: assert property (!PANEL_O.shift_clock |-> $stable(PANEL_O.data))
      else $error("data moved while clock low");
   AST_COL_HOLD: assert property (|PANEL_O.column |=>
      PANEL_O.column == $past(PANEL_O.column) || SLOT_START_O)
      else $error("column changed inside slot");
   AST_ROW_DOWN: assert property ($changed(DEC_REQ_O.row) && DEC_REQ_O.row != 3'h7 |->
      DEC_REQ_O.row == $past(DEC_REQ_O.row) - 3'h1)
      else $error("row order wrong");
endmodule : lmsr_refresh_ctrl_monitor
bind lmsr_refresh_ctrl lmsr_refresh_ctrl_monitor #(
   .CHARS(CHARS), .SLOT_CYCLES(SLOT_CYCLES)
) mon_u (
   .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .DEC_REQ_O(DEC_REQ_O),
   .PANEL_O(PANEL_O), .SLOT_START_O(SLOT_START_O)
);
`default_nettype wire

// file: tb/test_lmsr_refresh_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module test_lmsr_refresh_ctrl;
   localparam int NC = 4;
   localparam int SC = 1200;
   logic                    CLOCK_I = 1'b0;
   logic                    SRST_I = 1'b1;
   logic                    SYM_WR_I = 1'b0;
   logic [1:0]              SYM_ADDR_I = 2'h0;
   logic [6:0]              SYM_DATA_I = 7'h00;
   logic [15:0]             BLANK_TIME_I = 16'h0000;
   logic [4:0]              DEC_COLS_I = 5'h00;
   lmsr_pkg::lmsr_dec_req_t DEC_REQ_O;
   lmsr_pkg::lmsr_panel_t   PANEL_O;
   logic                    SLOT_START_O;
   logic [27:0]             stage;
   logic [27:0]             lit;
   logic                    sout;
   logic [6:0]              sym [4];
   int                      fails = 0;
   int                      checks_done = 0;
   lmsr_refresh_ctrl #(.CHARS(NC), .SLOT_CYCLES(SC)) dut_u (
      .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .SYM_WR_I(SYM_WR_I), .SYM_ADDR_I(SYM_ADDR_I),
      .SYM_DATA_I(SYM_DATA_I), .BLANK_TIME_I(BLANK_TIME_I), .DEC_COLS_I(DEC_COLS_I),
      .DEC_REQ_O(DEC_REQ_O), .PANEL_O(PANEL_O), .SLOT_START_O(SLOT_START_O));
   lmsr_panel_model #(.CHARS(NC)) model_u (
      .panel_i(PANEL_O), .stage_o(stage), .lit_o(lit), .sout_o(sout));
   always #25 CLOCK_I = ~CLOCK_I;
   // ====================
   // Registered decoder, one cycle behind its request
   function automatic logic [4:0] dec(input logic [6:0] s, input logic [2:0] r);
      return s[4:0] ^ {r, r[1:0]};
   endfunction : dec
   always @(posedge CLOCK_I) DEC_COLS_I <= dec(DEC_REQ_O.symbol, DEC_REQ_O.row);
   function automatic logic [27:0] pattern(input int c);
      logic [27:0] p;
      logic [4:0]  d;
      for (int k = 0; k < NC; k++)
         for (int r = 1; r <= 7; r++) begin
            d = dec(sym[k], 3'(r));
            p[7*k+r-1] = d[c];
         end
      return p;
   endfunction : pattern
   // ====================
   // Shared tasks
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait for a lit column or a slot start
   task automatic wait_until(input bit col);
      int n;
      n = 0;
      do begin
         @(negedge CLOCK_I);
         n++;
      end while (!(col ? |PANEL_O.column : SLOT_START_O) && n < 2*SC);
      if (n >= 2*SC) begin
         fails++;
         complete_run();
      end
   endtask : wait_until
   task automatic t_write(input logic [27:0] v);
      for (int k = 0; k < NC; k++) begin
         @(posedge CLOCK_I);
         SYM_WR_I <= 1'b1;
         SYM_ADDR_I <= 2'(k);
         SYM_DATA_I <= v[7*k +: 7];
         sym[k] = v[7*k +: 7];
      end
      @(posedge CLOCK_I);
      SYM_WR_I <= 1'b0;
      $display("symbols written");
   endtask : t_write
   // ====================
   // Scenarios
   // Expected column comes from the slot count, never from the pins
   task automatic t_refresh(input int slots, input int first, input bit sync);
      int          c;
      logic [27:0] p;
      c = first;
      if (sync)
         wait_until(1'b0);
      for (int s = 0; s < slots; s++) begin
         wait_until(1'b1);
         p = pattern(c);
         chk(PANEL_O.column, 32'(5'h01 << c));
         chk(lit, p);
         chk(sout, p[27]);
         wait_until(1'b0);
         c = (c + 1) % 5;
      end
      $display("refresh test done");
   endtask : t_refresh
   task automatic on_time(input logic [15:0] b, output int on, output int len);
      @(posedge CLOCK_I);
      BLANK_TIME_I <= b;
      wait_until(1'b0);
      wait_until(1'b0);
      on = 0;
      len = 0;
      do begin
         @(negedge CLOCK_I);
         len++;
         if (|PANEL_O.column) on++;
      end while (!SLOT_START_O && len < 2*SC);
      if (len >= 2*SC) begin
         fails++;
         complete_run();
      end
   endtask : on_time
   // Oversized blank must be clamped, never stretch the slot
   task automatic t_blank;
      int on0, on1, on2, len;
      on_time(16'h0000, on0, len);
      chk(len, SC);
      on_time(16'h012C, on1, len);
      chk(on0 - on1, 300);
      on_time(16'hFFFF, on2, len);
      chk(len, SC);
      chk(on2 < on1, 1);
      chk(on2 > 0, 1);
      @(posedge CLOCK_I);
      BLANK_TIME_I <= 16'h0000;
      $display("blank test done");
   endtask : t_blank
   task automatic t_reset;
      wait_until(1'b1);
      @(posedge CLOCK_I);
      SRST_I <= 1'b1;
      repeat (2) @(posedge CLOCK_I);
      @(negedge CLOCK_I);
      chk(PANEL_O, 8'h80);
      chk(DEC_REQ_O, 10'h007);
      @(posedge CLOCK_I);
      SRST_I <= 1'b0;
      t_refresh(6, 0, 1'b0);
      $display("reset test done");
   endtask : t_reset
   initial begin
      repeat (3) @(posedge CLOCK_I);
      SRST_I <= 1'b0;
      t_write(28'h82C3B95);
      t_refresh(6, 1, 1'b1);
      t_blank();
      t_write(28'h7F0015A);
      t_reset();
      complete_run();
   end
endmodule : test_lmsr_refresh_ctrl
`default_nettype wire
